// ==== hw/tkc_core.sv ====
// tick compare, count gating and service key decoder
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RQ1) arm value arms; service value while armed services
// (RQ2) service value while unarmed does nothing
// (RQ3) any other key value requests system reset
// (RQ4) software writes arm then service separately
// (RQ5) first match field versus counter bits 31:11
// (RQ6) second match field versus counter bits 31:11
// (RQ7) writes need privilege; reads always allowed
// (RQ8) match value bits 31:21 ignore writes
// (RQ9) bit 7 first flag, write zero clears
// (RQ10) bit 6 second flag, write zero clears
// (RQ11) bit 5 enables first match request
// (RQ12) bit 4 enables second match request
// (RQ13) request high while flag and enable set
// (RQ14) gate code selects modes where counting runs
// (RQ15) reserved control bits ignore writes
module tkc_core
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register port
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic        priv,
	output logic      [31:0] rdata,
	// counter side
	input  wire logic [31:0] counter,
	output logic             count_gate,
	// events out
	output logic             wd_service,
	output logic             sys_reset_req,
	output logic             match1_irq,
	output logic             match2_irq,
	output logic             irq
);
	import tkc_pkg::*;

	logic [TKC_CMP_W-1:0] cmp1_r;    // first match field
	logic [TKC_CMP_W-1:0] cmp2_r;    // second match field
	logic                 flag1_r;   // first match flag
	logic                 flag2_r;   // second match flag
	logic                 ena1_r;    // first match irq enable
	logic                 ena2_r;    // second match irq enable
	logic [1:0]           gate_r;    // count gate field
	tkc_key_e             key_r;     // key decoder state
	logic                 svc_r;     // service pulse
	logic                 bad_r;     // bad key pulse
	logic [TKC_NIRQ-1:0]  istat_r;   // sticky irq status
	logic [TKC_NIRQ-1:0]  imask_r;   // irq mask
	logic [31:0]          rdata_nxt; // read mux
	logic                 hit1;      // counter equals first field
	logic                 hit2;      // counter equals second field
	logic [TKC_NIRQ-1:0]  ev_set;    // events that set status bits
	logic                 key_wr;    // privileged write to the key

	// privileged write decode, shared by every register
	function automatic logic pwr(input logic [31:0] a,
			input logic [31:0] want, input logic w, input logic p);
		pwr = w && p && (a == want); // [RQ7]
	endfunction : pwr

	assign key_wr = pwr(addr, TKC_ADDR_KEY, wr, priv);
	// only the counter's upper 21 bits take part in the match
	assign hit1   = counter[31:TKC_CNT_LSB] == cmp1_r; // [RQ5]
	assign hit2   = counter[31:TKC_CNT_LSB] == cmp2_r; // [RQ6]

	// match value registers; high bits are never stored
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp1_r <= '0;
			cmp2_r <= '0;
		end else begin
			if (pwr(addr, TKC_ADDR_CMP1, wr, priv))
				cmp1_r <= wdata[TKC_CMP_W-1:0]; // [RQ8]
			if (pwr(addr, TKC_ADDR_CMP2, wr, priv))
				cmp2_r <= wdata[TKC_CMP_W-1:0]; // [RQ8]
		end
	end

	// match flags: a match in the clearing cycle keeps the flag set
	always_ff @(posedge clk) begin
		if (rst) begin
			flag1_r <= 1'b0;
			flag2_r <= 1'b0;
		end else begin
			if (hit1)
				flag1_r <= 1'b1; // [RQ5]
			else if (pwr(addr, TKC_ADDR_CINT, wr, priv) && !wdata[TKC_B_F1])
				flag1_r <= 1'b0; // [RQ9]
			if (hit2)
				flag2_r <= 1'b1; // [RQ6]
			else if (pwr(addr, TKC_ADDR_CINT, wr, priv) && !wdata[TKC_B_F2])
				flag2_r <= 1'b0; // [RQ10]
		end
	end

	// enables and count gate; reserved bits are simply not stored
	always_ff @(posedge clk) begin
		if (rst) begin
			ena1_r <= 1'b0;
			ena2_r <= 1'b0;
			gate_r <= TKC_GATE_ALL;
		end else begin
			if (pwr(addr, TKC_ADDR_CINT, wr, priv)) begin
				ena1_r <= wdata[TKC_B_E1]; // [RQ11] [RQ15]
				ena2_r <= wdata[TKC_B_E2]; // [RQ12]
			end
			if (pwr(addr, TKC_ADDR_GATE, wr, priv))
				gate_r <= wdata[1:0]; // [RQ15]
		end
	end

	// count gate follows the cpu mode seen this cycle
	always_comb begin
		case (gate_r)
			TKC_GATE_ALL:  count_gate = 1'b1; // [RQ14]
			TKC_GATE_PRIV: count_gate = priv;
			TKC_GATE_USER: count_gate = !priv;
			TKC_GATE_NONE: count_gate = 1'b0;
			default:       count_gate = 1'b0;
		endcase
	end

	// request lines are plain levels of flag and enable
	assign match1_irq = flag1_r && ena1_r; // [RQ11] [RQ13]
	assign match2_irq = flag2_r && ena2_r; // [RQ12] [RQ13]

	// key decoder; the key sits in the low byte, upper bits must be zero
	always_ff @(posedge clk) begin
		if (rst) begin
			key_r <= TKC_IDLE;
			svc_r <= 1'b0;
			bad_r <= 1'b0;
		end else begin
			svc_r <= 1'b0;
			bad_r <= 1'b0;
			if (key_wr) begin
				if (wdata == {24'h000000, TKC_KEY_ARM}) begin
					key_r <= TKC_ARMED; // [RQ1] [RQ4]
				end else if (wdata == {24'h000000, TKC_KEY_SVC}) begin
					case (key_r)
						TKC_ARMED: svc_r <= 1'b1; // [RQ1]
						TKC_IDLE:  svc_r <= 1'b0; // [RQ2]
						default:   svc_r <= 1'b0;
					endcase
					key_r <= TKC_IDLE; // [RQ2]
				end else begin
					bad_r <= 1'b1; // [RQ3]
					key_r <= TKC_IDLE;
				end
			end
		end
	end
	assign wd_service    = svc_r;
	assign sys_reset_req = bad_r;

	// status set sources, in status bit order
	assign ev_set = {bad_r, svc_r, hit2, hit1};

	// sticky status: set wins over write-one-to-clear
	always_ff @(posedge clk) begin
		if (rst) begin
			istat_r <= '0;
			imask_r <= '0;
		end else begin
			for (int i = 0; i < TKC_NIRQ; i++) begin
				if (ev_set[i])
					istat_r[i] <= 1'b1;
				else if (pwr(addr, TKC_ADDR_ISTAT, wr, priv) && wdata[i])
					istat_r[i] <= 1'b0;
			end
			if (pwr(addr, TKC_ADDR_IMASK, wr, priv))
				imask_r <= wdata[TKC_NIRQ-1:0];
		end
	end
	assign irq = |(istat_r & imask_r);

	// read mux; reserved bits and the key read as zero
	always_comb begin
		rdata_nxt = TKC_ZERO;
		case (addr)
			TKC_ADDR_CMP1:  rdata_nxt[TKC_CMP_W-1:0] = cmp1_r; // [RQ7]
			TKC_ADDR_CMP2:  rdata_nxt[TKC_CMP_W-1:0] = cmp2_r;
			TKC_ADDR_CINT: begin
				rdata_nxt[TKC_B_F1] = flag1_r; // [RQ9]
				rdata_nxt[TKC_B_F2] = flag2_r; // [RQ10]
				rdata_nxt[TKC_B_E1] = ena1_r;
				rdata_nxt[TKC_B_E2] = ena2_r;
			end
			TKC_ADDR_GATE:  rdata_nxt[1:0] = gate_r;
			TKC_ADDR_ISTAT: rdata_nxt[TKC_NIRQ-1:0] = istat_r;
			TKC_ADDR_IMASK: rdata_nxt[TKC_NIRQ-1:0] = imask_r;
			default:        rdata_nxt = TKC_ZERO;
		endcase
	end

	// read data registered, valid only the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst)
			rdata <= TKC_ZERO;
		else if (rd)
			rdata <= rdata_nxt;
		else
			rdata <= TKC_ZERO;
	end

	// checks
	property p_svc;
		@(posedge clk) disable iff (rst)
		key_wr && wdata == {24'h000000, TKC_KEY_SVC} && key_r == TKC_ARMED
		|=> wd_service && key_r == TKC_IDLE;
	endproperty
	a_svc: assert property (p_svc) else $error("service missed"); // [RQ1]
	property p_nosvc;
		@(posedge clk) disable iff (rst)
		key_wr && key_r == TKC_IDLE |=> !wd_service;
	endproperty
	a_nosvc: assert property (p_nosvc) else $error("stray service"); // [RQ2]
	property p_bad;
		@(posedge clk) disable iff (rst)
		key_wr && wdata != {24'h000000, TKC_KEY_SVC}
		&& wdata != {24'h000000, TKC_KEY_ARM} |=> sys_reset_req;
	endproperty
	a_bad: assert property (p_bad) else $error("bad key no reset"); // [RQ3]
	property p_arm;
		@(posedge clk) disable iff (rst)
		key_wr && wdata == {24'h000000, TKC_KEY_ARM} |=> key_r == TKC_ARMED;
	endproperty
	a_arm: assert property (p_arm) else $error("not armed"); // [RQ1]
	property p_f1;
		@(posedge clk) disable iff (rst)
		hit1 |=> flag1_r;
	endproperty
	a_f1: assert property (p_f1) else $error("flag1 not set"); // [RQ5]
	property p_f2;
		@(posedge clk) disable iff (rst)
		hit2 |=> flag2_r;
	endproperty
	a_f2: assert property (p_f2) else $error("flag2 not set"); // [RQ6]
	property p_upriv;
		@(posedge clk) disable iff (rst)
		wr && !priv |=> $stable(cmp1_r) && $stable(gate_r);
	endproperty
	a_upriv: assert property (p_upriv) else $error("user write took"); // [RQ7]
	property p_irq1;
		@(posedge clk) disable iff (rst)
		hit1 && ena1_r && !pwr(addr, TKC_ADDR_CINT, wr, priv)
		|=> match1_irq;
	endproperty
	a_irq1: assert property (p_irq1) else $error("irq1 wrong"); // [RQ13]
	property p_clr1;
		@(posedge clk) disable iff (rst)
		pwr(addr, TKC_ADDR_CINT, wr, priv) && !wdata[TKC_B_F1] && !hit1
		|=> !flag1_r;
	endproperty
	a_clr1: assert property (p_clr1) else $error("flag1 kept"); // [RQ9]
	property p_gate;
		@(posedge clk) disable iff (rst)
		gate_r == TKC_GATE_NONE |-> !count_gate;
	endproperty
	a_gate: assert property (p_gate) else $error("gate wrong"); // [RQ14]
	c_svc: cover property (@(posedge clk) wd_service);
	c_bad: cover property (@(posedge clk) sys_reset_req);
	c_irq: cover property (@(posedge clk) irq);
	c_hit1: cover property (@(posedge clk) match1_irq);
endmodule : tkc_core
`default_nettype wire

// ==== include/tkc_pkg.sv ====
// package: register map, fields and constants of the tick compare/key block
package tkc_pkg;
	// register byte addresses on the plain register port
	localparam logic [31:0] TKC_ADDR_KEY   = 32'hFFFFFF0C; // service key
	localparam logic [31:0] TKC_ADDR_CMP1  = 32'hFFFFFF10; // first match
	localparam logic [31:0] TKC_ADDR_CMP2  = 32'hFFFFFF14; // second match
	localparam logic [31:0] TKC_ADDR_CINT  = 32'hFFFFFF18; // match irq ctrl
	localparam logic [31:0] TKC_ADDR_GATE  = 32'hFFFFFF1C; // count gate
	localparam logic [31:0] TKC_ADDR_ISTAT = 32'hFFFFFF20; // irq status
	localparam logic [31:0] TKC_ADDR_IMASK = 32'hFFFFFF24; // irq mask
	// match field geometry
	localparam int          TKC_CMP_W      = 21;
	localparam int          TKC_CNT_LSB    = 11;
	// key values
	localparam logic [7:0]  TKC_KEY_ARM    = 8'hE5;
	localparam logic [7:0]  TKC_KEY_SVC    = 8'hA3;
	// control register bit positions
	localparam int          TKC_B_F1       = 7;
	localparam int          TKC_B_F2       = 6;
	localparam int          TKC_B_E1       = 5;
	localparam int          TKC_B_E2       = 4;
	// count gate codes
	localparam logic [1:0]  TKC_GATE_ALL   = 2'h0;
	localparam logic [1:0]  TKC_GATE_PRIV  = 2'h1;
	localparam logic [1:0]  TKC_GATE_USER  = 2'h2;
	localparam logic [1:0]  TKC_GATE_NONE  = 2'h3;
	// irq status bits: 0 first match, 1 second match, 2 service, 3 bad key
	localparam int          TKC_NIRQ       = 4;
	localparam logic [31:0] TKC_ZERO       = 32'h00000000;
	// key decoder states, gray along idle -> armed
	typedef enum logic [0:0] {
		TKC_IDLE  = 1'b0,
		TKC_ARMED = 1'b1
	} tkc_key_e;
endpackage : tkc_pkg

// ==== sim/tkc_core_test.sv ====
// testbench for the tick compare and service key block
`timescale 1ns/1ps
`default_nettype none
module tkc_core_test;
	import tkc_pkg::*;
	// bench side of every port
	logic        clk, rst, wr, rd, priv, count_gate, wd_service;
	logic        sys_reset_req, match1_irq, match2_irq, irq;
	logic [31:0] addr, wdata, counter, rdata, got;
	int          n_fail = 0;  // mismatches
	int          checked = 0; // comparisons
	tkc_core tkc_core_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .priv(priv), .rdata(rdata), .counter(counter),
		.count_gate(count_gate), .wd_service(wd_service),
		.sys_reset_req(sys_reset_req), .match1_irq(match1_irq),
		.match2_irq(match2_irq), .irq(irq));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// compare a word; case equality so unknowns never match
	task automatic chk(input string what, input logic [31:0] seen, want);
		checked++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask : chk
	// compare a single bit
	task automatic chkb(input string what, input logic seen, want);
		chk(what, {31'h0, seen}, {31'h0, want});
	endtask : chkb
	// one write; returns just after the edge that takes it
	task automatic wreg(input logic [31:0] a, d, input logic p);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		priv <= p;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wreg
	// one read; data stand only in the cycle after the strobe
	task automatic rreg(input logic [31:0] a, input logic p);
		@(posedge clk);
		addr <= a;
		priv <= p;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask : rreg
	// reset values, privilege, reserved bits and the count gate
	task automatic t_regs();
		logic [31:0] a;
		logic        e;
		rreg(TKC_ADDR_CINT, 1'b0);
		chk("cint reset", got, TKC_ZERO);
		chkb("gate reset", count_gate, 1'b1);
		for (int i = 0; i < 2; i++) begin
			a = i ? TKC_ADDR_CMP2 : TKC_ADDR_CMP1;
			wreg(a, 32'hFFFFFFFF, 1'b1);
			wreg(a, TKC_ZERO, 1'b0);
			rreg(a, 1'b0);
			chk("match value", got, 32'h001FFFFF);
			wreg(a, TKC_ZERO, 1'b1);
		end
		wreg(TKC_ADDR_CINT, 32'hFFFFFF3F, 1'b1);
		rreg(TKC_ADDR_CINT, 1'b0);
		chk("cint", got, 32'h00000030);
		wreg(TKC_ADDR_CINT, TKC_ZERO, 1'b1);
		rreg(32'hFFFFFF40, 1'b1);
		chk("unmapped", got, TKC_ZERO);
		for (logic [2:0] c = 0; c < 4; c++) begin
			wreg(TKC_ADDR_GATE, {29'h1FFFFFFF, c}, 1'b1);
			rreg(TKC_ADDR_GATE, 1'b0);
			chk("gate", got, {30'h0, c[1:0]});
			for (int p = 0; p < 2; p++) begin
				@(posedge clk);
				priv <= p[0];
				#1;
				e = (c == 0) | (c == 1 & p == 1) | (c == 2 & p == 0);
				chkb("count gate", count_gate, e);
			end
		end
		// gate now stops counting; a user write must not reopen it
		wreg(TKC_ADDR_GATE, TKC_ZERO, 1'b0);
		chkb("gate user", count_gate, 1'b0);
		wreg(TKC_ADDR_GATE, TKC_ZERO, 1'b1);
		$display("register test done");
	endtask : t_regs
	// key walk; index 1 arms from user mode and must be ignored
	task automatic t_key();
		logic [7:0] v [8] = '{8'hA3, 8'hE5, 8'hA3, 8'hE5, 8'hE5, 8'hA3,
			8'hA3, 8'h23};
		logic [7:0] pm = 8'hFD; // privilege per write
		logic [7:0] sv = 8'h20; // service expected only at index 5
		for (int i = 0; i < 8; i++) begin
			wreg(TKC_ADDR_KEY, {24'h0, v[i]}, pm[i]);
			chkb("service", wd_service, sv[i]);
			chkb("bad key", sys_reset_req, i == 7);
		end
		$display("key test done");
	endtask : t_key
	// sticky status, mask and the level interrupt
	task automatic t_irq();
		rreg(TKC_ADDR_ISTAT, 1'b0);
		chk("status", got, 32'h0000000C);
		chkb("irq masked", irq, 1'b0);
		wreg(TKC_ADDR_IMASK, 32'h00000004, 1'b1);
		chkb("irq", irq, 1'b1);
		wreg(TKC_ADDR_ISTAT, 32'h00000004, 1'b1);
		chkb("irq cleared", irq, 1'b0);
		rreg(TKC_ADDR_ISTAT, 1'b0);
		chk("status", got, 32'h00000008);
		wreg(TKC_ADDR_ISTAT, 32'h00000008, 1'b1);
		wreg(TKC_ADDR_IMASK, 32'h0000000F, 1'b1);
		$display("irq test done");
	endtask : t_irq
	// near miss, hit with low bits set, then flag and enable handling
	task automatic t_match();
		logic [31:0] a, f, e;
		for (int i = 0; i < 2; i++) begin
			a = i ? TKC_ADDR_CMP2 : TKC_ADDR_CMP1;
			f = i ? 32'h00000040 : 32'h00000080;
			e = i ? 32'h00000010 : 32'h00000020;
			wreg(a, 32'h000ABCDE, 1'b1);
			wreg(TKC_ADDR_CINT, e, 1'b1);
			@(posedge clk);
			counter <= 32'h55E6EFFF;
			@(posedge clk);
			counter <= 32'h55E6F7FF;
			#1;
			chkb("near miss", i ? match2_irq : match1_irq, 1'b0);
			@(posedge clk);
			counter <= 32'h80000000;
			#1;
			chkb("hit", i ? match2_irq : match1_irq, 1'b1);
			chkb("other", i ? match1_irq : match2_irq, 1'b0);
			chkb("irq", irq, 1'b1);
			rreg(TKC_ADDR_CINT, 1'b0);
			chk("flag", got, f | e);
			wreg(TKC_ADDR_CINT, f, 1'b1);
			chkb("off", i ? match2_irq : match1_irq, 1'b0);
			wreg(TKC_ADDR_CINT, TKC_ZERO, 1'b0);
			rreg(TKC_ADDR_CINT, 1'b0);
			chk("flag kept", got, f);
			wreg(TKC_ADDR_CINT, TKC_ZERO, 1'b1);
			rreg(TKC_ADDR_CINT, 1'b0);
			chk("flag clear", got, TKC_ZERO);
			// park the match value so the next pass sees only its own hit
			wreg(a, TKC_ZERO, 1'b1);
			wreg(TKC_ADDR_ISTAT, 32'h0000000F, 1'b1);
			chkb("irq idle", irq, 1'b0);
		end
		$display("match test done");
	endtask : t_match
	// counts, verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	// main sequence; counter parked where no match value sits
	initial begin
		{wr, rd, priv, addr, wdata} = '0;
		counter = 32'h80000000;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_key();
		t_irq();
		t_match();
		test_done();
	end
	// watchdog well past the 130 or so cycles the tests need
	initial begin
		#40000;
		n_fail++;
		test_done();
	end
endmodule : tkc_core_test
`default_nettype wire
